// [rtl/bitset_pkg.sv]
// package: encodings, widths, address map and state types of the bit-set executor
package bitset_pkg;

  // ------------------------------------------------------------
  // instruction word layout
  // ------------------------------------------------------------
  localparam int INSTR_W = 16;
  localparam logic [3:0] SET_BIT_OPCODE = 4'h8; // upper nibble of the set-bit op
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int BIT_HI = 11;
  localparam int BIT_LO = 9;
  localparam int ACC_POS = 8;
  localparam int FADDR_HI = 7;
  localparam int FADDR_LO = 0;

  // ------------------------------------------------------------
  // data-space geometry
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60; // lower access half ends below this
  localparam logic [7:0] INDEXED_MAX = 8'h5f; // literal offsets reach this value
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0; // low half of the access bank
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf; // high half: special function area

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  // phase of the instruction cycle, gray coded from idle through write; leaving write changes more than one bit
  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_DECODE = 3'h1,
    PH_READ   = 3'h3,
    PH_PROC   = 3'h2,
    PH_WRITE  = 3'h6
  } phase_t;

  // decoded operand fields
  typedef struct packed {
    logic [2:0] bit_idx;
    logic access_sel;
    logic [7:0] faddr;
  } operand_t;

  // context captured with the instruction
  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] index_base;
    logic ext_en;
  } context_t;

  // register file request
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
  } rf_req_t;

  // whole state of the executor
  typedef struct packed {
    phase_t phase;
    operand_t op;
    context_t ctx;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic indexed;
  } exec_state_t;

  localparam exec_state_t EXEC_RESET = '{
    phase: PH_IDLE, op: '0, ctx: '0, addr: '0, data: '0, indexed: 1'b0
  };

endpackage

// [rtl/bitset_addr_resolve.sv]
// module: turns an 8-bit operand address and access flag into a full data address
`timescale 1ns/1ps
`default_nettype none
module bitset_addr_resolve
  import bitset_pkg::*;
(
  input wire logic [7:0] i_faddr,
  input wire logic i_access_sel,
  input wire logic i_ext_en,
  input wire logic [BANK_W-1:0] i_bank,
  input wire logic [ADDR_W-1:0] i_index_base,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_indexed
);

  // ------------------------------------------------------------
  // address selection
  // ------------------------------------------------------------
  // purely combinational; the caller registers the result
  always_comb
  begin
    o_indexed = 1'b0;
    if (i_access_sel)
    begin
      // pointer-selected bank, default form of the op
      o_addr = {i_bank, i_faddr};
    end
    else if (i_ext_en && (i_faddr <= INDEXED_MAX))
    begin
      // literal offset from the index base; wraps in data space
      o_addr = i_index_base + {{(ADDR_W-8){1'b0}}, i_faddr};
      o_indexed = 1'b1;
    end
    else if (i_faddr < ACCESS_SPLIT)
    begin
      o_addr = {ACCESS_LO_BANK, i_faddr};
    end
    else
    begin
      o_addr = {ACCESS_HI_BANK, i_faddr};
    end
  end

endmodule
`default_nettype wire

// [rtl/bitset_exec.sv]
// module: decode and execute logic for the single-word set-register-bit instruction
// Overview of operation
// - opcode 1000 sets chosen bit of register
// - access flag zero uses fixed access bank
// - access flag one uses bank pointer register
// - flag zero, extended, address <=95: indexed offset
`timescale 1ns/1ps
`default_nettype none
module bitset_exec
  import bitset_pkg::*;
#(
  parameter int P_DATA_W = DATA_W, // register width; bit index assumes eight
  parameter int P_ADDR_W = ADDR_W // data-space address width
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic i_ext_enable,
  input wire logic [BANK_W-1:0] i_bank_ptr,
  input wire logic [ADDR_W-1:0] i_index_base,
  input wire logic [DATA_W-1:0] i_rd_data,
  output logic o_ready,
  output logic o_taken,
  output logic o_rd_en,
  output logic o_wr_en,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wr_data,
  output logic o_indexed,
  output logic o_done
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // the three-bit index and the 8+4 bit address are fixed by the encoding
  if (P_DATA_W != 8)
  begin : g_bad_data_w
    $error("bitset_exec supports only eight-bit registers");
  end
  if (P_ADDR_W != BANK_W + 8)
  begin : g_bad_addr_w
    $error("bitset_exec address width must be bank plus eight bits");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one-hot mask for a bit index
  function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] idx);
    bit_mask = {{(DATA_W-1){1'b0}}, 1'b1} << idx;
  endfunction

  // opcode match for an instruction word
  function automatic logic is_set_bit_op(input logic [INSTR_W-1:0] w);
    is_set_bit_op = (w[OPC_HI:OPC_LO] == SET_BIT_OPCODE);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  exec_state_t st_q; // registered state
  exec_state_t st_d; // next state
  logic take; // instruction accepted this cycle
  logic [ADDR_W-1:0] res_addr; // resolved address from the decode stage
  logic res_indexed; // resolved address came from the index base
  rf_req_t req; // register file request view of the state

  // ------------------------------------------------------------
  // address resolution
  // ------------------------------------------------------------
  // fed from captured fields so a bank pointer change mid-cycle is ignored
  bitset_addr_resolve bitset_addr_resolve_i (
    .i_faddr(st_q.op.faddr),
    .i_access_sel(st_q.op.access_sel),
    .i_ext_en(st_q.ctx.ext_en),
    .i_bank(st_q.ctx.bank),
    .i_index_base(st_q.ctx.index_base),
    .o_addr(res_addr),
    .o_indexed(res_indexed)
  );

  // ------------------------------------------------------------
  // acceptance
  // ------------------------------------------------------------
  // a new word is taken while idle or in the write phase, so ops run back to back
  assign o_ready = (st_q.phase == PH_IDLE) || (st_q.phase == PH_WRITE);
  // other opcodes are left to the rest of the core and never taken here
  assign take = i_ce && o_ready && i_instr_valid && is_set_bit_op(i_instr);
  assign o_taken = take;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q.phase)
      PH_IDLE, PH_WRITE:
      begin
        // capture fields and context together with the word
        if (take)
        begin
          st_d.phase = PH_DECODE;
          st_d.op.bit_idx = i_instr[BIT_HI:BIT_LO];
          st_d.op.access_sel = i_instr[ACC_POS];
          st_d.op.faddr = i_instr[FADDR_HI:FADDR_LO];
          st_d.ctx.bank = i_bank_ptr;
          st_d.ctx.index_base = i_index_base;
          st_d.ctx.ext_en = i_ext_enable;
        end
        else
        begin
          st_d.phase = PH_IDLE;
        end
      end
      PH_DECODE:
      begin
        // first quarter: fix the operand address
        st_d.addr = res_addr;
        st_d.indexed = res_indexed;
        st_d.phase = PH_READ;
      end
      PH_READ:
      begin
        // second quarter: register file answers in the same cycle
        st_d.data = i_rd_data;
        st_d.phase = PH_PROC;
      end
      PH_PROC:
      begin
        // third quarter: only the chosen bit changes, status is untouched
        st_d.data = st_q.data | bit_mask(st_q.op.bit_idx);
        st_d.phase = PH_WRITE;
      end
      default:
      begin
        st_d = EXEC_RESET;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // clock enable low freezes the whole cycle in place
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_q <= EXEC_RESET;
    end
    else if (i_ce)
    begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb
  begin
    req.rd_en = (st_q.phase == PH_READ);
    req.wr_en = (st_q.phase == PH_WRITE);
    req.addr = st_q.addr;
    req.wr_data = st_q.data;
  end

  assign o_rd_en = req.rd_en;
  assign o_wr_en = req.wr_en;
  assign o_addr = req.addr;
  assign o_wr_data = req.wr_data;
  assign o_indexed = st_q.indexed;
  // end of the instruction cycle
  assign o_done = req.wr_en && i_ce;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // a taken word followed by three enabled quarters
  sequence s_quarters;
    take ##1 i_ce[*3];
  endsequence

  // phases are looked back on from the write quarter, so a stall voids the check
  property p_one_cycle;
    @(posedge i_clk) disable iff (i_reset)
    s_quarters |=> st_q.phase == PH_WRITE && $past(st_q.phase, 1) == PH_PROC &&
      $past(st_q.phase, 2) == PH_READ && $past(st_q.phase, 3) == PH_DECODE;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("set-bit op did not run decode, read, process, write");

  property p_set_bit;
    @(posedge i_clk) disable iff (i_reset)
    (st_q.phase == PH_READ && i_ce) ##1 (st_q.phase == PH_PROC && i_ce)
      |=> o_wr_en && o_wr_data == ($past(i_rd_data, 2) | bit_mask(st_q.op.bit_idx));
  endproperty
  a_set_bit: assert property (p_set_bit)
    else $error("written value is not read value with chosen bit set");

  property p_addr_held;
    @(posedge i_clk) disable iff (i_reset)
    $rose(o_wr_en) |-> o_addr == $past(o_addr, 2);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("write address differs from read address");

  property p_access_bank;
    @(posedge i_clk) disable iff (i_reset)
    (o_rd_en && !st_q.op.access_sel && !(st_q.ctx.ext_en && st_q.op.faddr <= INDEXED_MAX)) |->
      !o_indexed && o_addr[FADDR_HI:FADDR_LO] == st_q.op.faddr &&
      o_addr[ADDR_W-1:ADDR_W-BANK_W] == ((st_q.op.faddr < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK);
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access-bank address resolved wrongly");

  property p_pointer_bank;
    @(posedge i_clk) disable iff (i_reset)
    (o_rd_en && st_q.op.access_sel) |-> o_addr == {st_q.ctx.bank, st_q.op.faddr} && !o_indexed;
  endproperty
  a_pointer_bank: assert property (p_pointer_bank)
    else $error("pointer-bank address resolved wrongly");

  property p_indexed;
    @(posedge i_clk) disable iff (i_reset)
    (o_rd_en && !st_q.op.access_sel && st_q.ctx.ext_en && st_q.op.faddr <= INDEXED_MAX)
      |-> o_indexed && o_addr == ADDR_W'(st_q.ctx.index_base + st_q.op.faddr);
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed literal offset address resolved wrongly");

endmodule
`default_nettype wire

// [tb/bit_set_register_instruction_test.sv]
// testbench: self-checking scenarios for the set-register-bit executor
`timescale 1ns/1ps
`default_nettype none
module bit_set_register_instruction_test
  import bitset_pkg::*;
;
  // ----------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------
  logic i_clk; // 40 mhz core clock
  logic i_reset; // synchronous, active high
  logic i_ce; // clock enable
  logic i_instr_valid;
  logic [INSTR_W-1:0] i_instr;
  logic i_ext_enable;
  logic [BANK_W-1:0] i_bank_ptr;
  logic [ADDR_W-1:0] i_index_base;
  logic [DATA_W-1:0] i_rd_data; // stands in for the register file
  logic o_ready, o_taken, o_rd_en, o_wr_en, o_indexed, o_done;
  logic [ADDR_W-1:0] o_addr;
  logic [DATA_W-1:0] o_wr_data;
  int fails = 0; // mismatches seen
  int tests_run = 0; // comparisons made

  bitset_exec bitset_exec_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_ext_enable(i_ext_enable), .i_bank_ptr(i_bank_ptr),
    .i_index_base(i_index_base), .i_rd_data(i_rd_data), .o_ready(o_ready),
    .o_taken(o_taken), .o_rd_en(o_rd_en), .o_wr_en(o_wr_en), .o_addr(o_addr),
    .o_wr_data(o_wr_data), .o_indexed(o_indexed), .o_done(o_done)
  );

  // ----------------------------------------------------------
  // clock, verdict and shared helpers
  // ----------------------------------------------------------
  // free-running clock, 25 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // single exit point of the run
  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one comparison; reports and counts a miss
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok)
    begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // one whole instruction, phase by phase; context is scrambled after take
  // so that late sampling of bank, base or ext shows up as a wrong address
  task automatic run_op(input logic [15:0] instr, input logic ext, input logic [3:0] bank,
                        input logic [11:0] base, input logic [7:0] rd, input logic [11:0] exp_addr,
                        input logic exp_idx);
    @(posedge i_clk);
    i_instr <= instr;
    i_instr_valid <= 1'b1;
    i_ext_enable <= ext;
    i_bank_ptr <= bank;
    i_index_base <= base;
    i_rd_data <= rd;
    #1 chk(o_taken === 1'b1 && o_ready === 1'b1, "word not taken");
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    i_ext_enable <= ~ext;
    i_bank_ptr <= ~bank;
    i_index_base <= ~base;
    #1 chk(o_ready === 1'b0 && o_rd_en === 1'b0, "decode phase");
    @(posedge i_clk);
    #1 chk(o_rd_en === 1'b1 && o_addr === exp_addr && o_indexed === exp_idx, "read phase");
    @(posedge i_clk);
    i_rd_data <= ~rd; // read data no longer valid after the read phase
    #1 chk(o_rd_en === 1'b0 && o_wr_en === 1'b0, "process phase");
    @(posedge i_clk);
    #1 chk(o_wr_en === 1'b1 && o_done === 1'b1 && o_ready === 1'b1 && o_addr === exp_addr
           && o_wr_data === (rd | (8'h01 << instr[11:9])), "write phase");
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  // every bit index, pointer bank, other bits must survive
  task automatic test_bit_positions();
    for (int b = 0; b < 8; b++)
      run_op({4'h8, 3'(b), 1'b1, 8'h3c}, 1'b0, 4'(2 * b + 1), 12'h000, ~(8'h01 << b),
             {4'(2 * b + 1), 8'h3c}, 1'b0);
    run_op({4'h8, 3'h7, 1'b1, 8'h44}, 1'b0, 4'h2, 12'h000, 8'h0a, 12'h244, 1'b0);
  endtask

  // fixed access bank, both halves and boundaries, pointer ignored; then flag one with extended on uses the pointer
  task automatic test_access_bank();
    run_op({4'h8, 3'h0, 1'b0, 8'h10}, 1'b0, 4'h9, 12'h000, 8'h00, 12'h010, 1'b0);
    run_op({4'h8, 3'h3, 1'b0, 8'h5f}, 1'b0, 4'h9, 12'h000, 8'h81, 12'h05f, 1'b0);
    run_op({4'h8, 3'h5, 1'b0, 8'h60}, 1'b0, 4'h9, 12'h000, 8'h00, 12'hf60, 1'b0);
    run_op({4'h8, 3'h6, 1'b0, 8'hff}, 1'b0, 4'h9, 12'h000, 8'h0f, 12'hfff, 1'b0);
    run_op({4'h8, 3'h1, 1'b1, 8'h10}, 1'b1, 4'h3, 12'h200, 8'h00, 12'h310, 1'b0);
  endtask

  // indexed literal offset at the 95 boundary and with address wrap
  task automatic test_indexed();
    run_op({4'h8, 3'h2, 1'b0, 8'h5f}, 1'b1, 4'h7, 12'h100, 8'h00, 12'h15f, 1'b1);
    run_op({4'h8, 3'h4, 1'b0, 8'h00}, 1'b1, 4'h7, 12'h0f0, 8'h10, 12'h0f0, 1'b1);
    run_op({4'h8, 3'h0, 1'b0, 8'h60}, 1'b1, 4'h7, 12'h100, 8'h00, 12'hf60, 1'b0);
    run_op({4'h8, 3'h7, 1'b0, 8'h01}, 1'b1, 4'h7, 12'hfff, 8'h00, 12'h000, 1'b1);
  endtask

  // other opcodes, and a set-bit word with the enable low, are ignored
  task automatic test_refused();
    for (int op = 0; op < 16; op++)
    begin
      @(posedge i_clk);
      i_instr <= {4'(op), 12'h155};
      i_instr_valid <= 1'b1;
      i_ce <= (op != 8);
      #1 chk(o_taken === 1'b0 && o_ready === 1'b1 && o_rd_en === 1'b0, "stray word taken");
    end
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    i_ce <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk(o_rd_en === 1'b0 && o_ready === 1'b1, "ignored word started a cycle");
  endtask

  // a second word offered in the write quarter of the first is taken at once
  task automatic test_back_to_back();
    @(posedge i_clk);
    i_instr <= {4'h8, 3'h1, 1'b1, 8'h20};
    i_instr_valid <= 1'b1;
    i_ext_enable <= 1'b0;
    i_bank_ptr <= 4'h5;
    i_rd_data <= 8'h40;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_instr <= {4'h8, 3'h7, 1'b1, 8'h21};
    i_instr_valid <= 1'b1;
    i_bank_ptr <= 4'h6;
    #1 chk(o_wr_en === 1'b1 && o_taken === 1'b1, "no take in write quarter");
    chk(o_addr === 12'h520 && o_wr_data === 8'h42, "first write");
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    i_rd_data <= 8'h01;
    #1 chk(o_wr_en === 1'b0 && o_ready === 1'b0, "second decode");
    @(posedge i_clk);
    #1 chk(o_rd_en === 1'b1 && o_addr === 12'h621, "second read");
    repeat (2) @(posedge i_clk);
    #1 chk(o_wr_en === 1'b1 && o_addr === 12'h621 && o_wr_data === 8'h81, "second write");
  endtask

  // clock enable low freezes the decode, read and write quarters; done waits for the enable
  task automatic test_stall();
    @(posedge i_clk);
    i_instr <= {4'h8, 3'h3, 1'b0, 8'h70};
    i_instr_valid <= 1'b1;
    i_ext_enable <= 1'b1;
    i_rd_data <= 8'h00;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    i_ce <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_ce <= 1'b1;
    #1 chk(o_ready === 1'b0 && o_rd_en === 1'b0, "decode not held");
    @(posedge i_clk);
    i_ce <= 1'b0;
    #1 chk(o_rd_en === 1'b1 && o_addr === 12'hf70 && o_indexed === 1'b0, "stalled read");
    @(posedge i_clk);
    i_ce <= 1'b1;
    #1 chk(o_rd_en === 1'b1, "read not held");
    repeat (2) @(posedge i_clk);
    i_ce <= 1'b0;
    #1 chk(o_wr_en === 1'b1 && o_done === 1'b0 && o_wr_data === 8'h08, "done while frozen");
    @(posedge i_clk);
    i_ce <= 1'b1;
    #1 chk(o_wr_en === 1'b1 && o_done === 1'b1, "write not held");
  endtask

  // a reset in the middle of a cycle drops the op and returns to idle
  task automatic test_reset_mid();
    @(posedge i_clk);
    i_instr <= {4'h8, 3'h0, 1'b1, 8'h11};
    i_instr_valid <= 1'b1;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b1;
    @(posedge i_clk);
    i_reset <= 1'b0;
    #1 chk(o_ready === 1'b1 && o_wr_en === 1'b0 && o_done === 1'b0, "op survived reset");
  endtask

  // ----------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------
  // reset for two cycles, then the scenarios in turn
  initial
  begin
    i_reset = 1'b1;
    i_ce = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = '0;
    i_ext_enable = 1'b0;
    i_bank_ptr = '0;
    i_index_base = '0;
    i_rd_data = '0;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    #1 chk(o_ready === 1'b1 && o_rd_en === 1'b0 && o_wr_en === 1'b0 && o_done === 1'b0, "reset state");
    test_bit_positions();
    test_access_bank();
    test_indexed();
    test_refused();
    test_back_to_back();
    test_stall();
    test_reset_mid();
    tally_and_finish();
  end

  // about 135 cycles are needed; a hang is cut well past that
  initial
  begin
    repeat (2000) @(posedge i_clk);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
